// ### hdl/tws_pkg.sv
// shared constants and types of the two-wire slave transmitter block
package tws_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] DATA_OFS = 8'h08;
    localparam logic [7:0] ADDR_OFS = 8'h0C;
    // control register bit positions
    localparam int FLAG_BIT = 7;
    localparam int ACK_BIT = 6;
    localparam int STA_REQ_BIT = 5;
    localparam int STO_REQ_BIT = 4;
    localparam int EN_BIT = 2;
    // status register field positions
    localparam int CODE_LSB = 3;
    localparam int PRESC_LSB = 0;
    // address register: own address in 7:1, general call enable in 0
    localparam int OWN_LSB = 1;
    localparam int GCE_BIT = 0;
    // values after reset
    localparam logic [7:0] DATA_RST = 8'hFF;
    localparam logic [6:0] OWN_RST = 7'h00;
    localparam logic [1:0] PRESC_RST = 2'h0;
    // status codes, prescaler bits masked
    localparam logic [7:0] SC_BUS_ERR = 8'h00;
    localparam logic [7:0] SC_START = 8'h08;
    localparam logic [7:0] SC_RSTART = 8'h10;
    localparam logic [7:0] SC_OWN_RD = 8'hA8;
    localparam logic [7:0] SC_ARB_RD = 8'hB0;
    localparam logic [7:0] SC_DATA_ACK = 8'hB8;
    localparam logic [7:0] SC_DATA_NACK = 8'hC0;
    localparam logic [7:0] SC_LAST_ACK = 8'hC8;
    localparam logic [7:0] SC_NONE = 8'hF8;
    // general call address and bit counts
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic [3:0] ADDR_BITS = 4'h8;
    localparam logic [3:0] DATA_LAST = 4'h7;
    // master condition phase timing
    localparam int CLK_NS = 10;
    localparam int T_PHASE_NS = 5000;
    localparam int PHASE_CYC = (T_PHASE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [9:0] PHASE_LD = 10'(PHASE_CYC - 1);
    // engine states
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ADDR = 4'h1,
        S_AACK = 4'h2,
        S_TX = 4'h3,
        S_TACK = 4'h4,
        S_HOLD = 4'h5,
        S_BERR = 4'h6,
        S_MSTART = 4'h7,
        S_MOWN = 4'h8,
        S_MRS = 4'h9,
        S_MRSH = 4'hA,
        S_MSTOP = 4'hB,
        S_MSTOPH = 4'hC
    } tws_state_type;
    // apb request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tws_apb_req_type;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tws_apb_rsp_type;
endpackage

// ### hdl/tws_slave_tx.sv
// two-wire slave transmitter engine with status codes and apb registers
//
// Notes on behaviour
// R1 - own address with read bit acknowledged: code A8, flag set
// R2 - addressed for read while waiting to be master: acknowledge, code B0
// R3 - data byte sent and acknowledged by master: code B8
// R4 - data byte sent and not acknowledged: code C0
// R5 - last byte sent, master still acknowledged: code C8
// R6 - software loads next byte, stop at 0, writes flag to continue
// R7 - ack enable 1 at load: normal byte, acknowledge expected
// R8 - ack enable 0 at load: last byte, not-acknowledge expected
// R9 - C0/C8 continue with ack enable 0: unaddressed, ignore all addresses
// R10 - with ack enable 1: unaddressed, own address, general call if enabled
// R11 - start request in C0/C8: start condition once bus is free
// R12 - status reads F8 whenever the flag is clear
// R13 - start or stop inside a frame: bus error, code 00, flag set
// R14 - software recovers by stop request plus flag write
// R15 - recovery: unaddressed, lines released, stop request cleared, no stop
// R16 - master places a repeated start between write and read phases
// R17 - after repeated start the device keeps the bus, never releases it
// R18 - software runs the whole combined access as one atomic sequence
// R19 - while flag is set the scl low period is stretched; in the bus error state scl is released
// R20 - status holds five code bits over two prescaler bits
// R21 - read direction enters slave transmit, write direction leaves it
// R22 - when unaddressed sda stays released, master reads all ones
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
module tws_slave_tx (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // apb slave
    input wire tws_pkg::tws_apb_req_type apb_req_in,
    output tws_pkg::tws_apb_rsp_type apb_rsp_out,
    // two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe_out,
    output logic sda_out,
    output logic sda_oe_out
);
    import tws_pkg::*;

    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;
    tws_apb_rsp_type rsp_r;
    logic flag_r;
    logic ack_en_r;
    logic sta_r;
    logic sto_r;
    logic en_r;
    logic go_r;
    logic busy_r;
    logic [1:0] presc_r;
    logic [7:0] data_r;
    logic [6:0] own_r;
    logic gce_r;
    logic [7:0] code_r;
    logic [7:0] code_nxt;
    tws_state_type state_r;
    tws_state_type state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic ackd_r;
    logic ackd_nxt;
    logic last_r;
    logic last_nxt;
    logic rs_r;
    logic rs_nxt;
    logic [9:0] tmr_r;
    logic flag_set;
    logic sto_clr;
    logic scl_oe_r;
    logic sda_oe_r;
    logic line_low_r;
    logic [7:0] ctrl_rd;

    // synchronisers; the first stage feeds only the second
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end

    // bus edges and conditions
    wire scl_now = scl_sync_r[1];
    wire sda_now = sda_sync_r[1];
    wire scl_rise = scl_now & ~scl_d_r;
    wire scl_fall = ~scl_now & scl_d_r;
    wire start_det = scl_now & scl_d_r & sda_d_r & ~sda_now;
    wire stop_det = scl_now & scl_d_r & ~sda_d_r & sda_now;

    // apb decode
    wire acc = apb_req_in.psel & apb_req_in.penable;
    wire done = acc & rsp_r.pready;
    wire wr_ev = done & apb_req_in.pwrite;
    wire hit_ctrl = apb_req_in.paddr == CTRL_OFS;
    wire hit_stat = apb_req_in.paddr == STAT_OFS;
    wire hit_data = apb_req_in.paddr == DATA_OFS;
    wire hit_addr = apb_req_in.paddr == ADDR_OFS;
    wire mapped = hit_ctrl | hit_stat | hit_data | hit_addr;
    wire ctl_wr = wr_ev & hit_ctrl;
    wire [7:0] wd = apb_req_in.pwdata[7:0];
    wire clr_go = ctl_wr & wd[FLAG_BIT] & flag_r;

    // read views of the registers
    wire [4:0] code_view = flag_r ? code_r[7:3] : SC_NONE[7:3]; // R12
    wire [7:0] stat_rd = {code_view, 1'b0, presc_r}; // R20
    wire [7:0] addr_rd = {own_r, gce_r};
    wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                         hit_stat ? stat_rd :
                         hit_data ? data_r :
                         hit_addr ? addr_rd : 8'h00;

    // control register layout, reserved bits zero
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[FLAG_BIT] = flag_r;
        ctrl_rd[ACK_BIT] = ack_en_r;
        ctrl_rd[STA_REQ_BIT] = sta_r;
        ctrl_rd[STO_REQ_BIT] = sto_r;
        ctrl_rd[EN_BIT] = en_r;
    end

    // apb answer after one wait cycle
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rsp_r <= '0;
        end else begin
            rsp_r.pready <= acc & ~rsp_r.pready;
            rsp_r.pslverr <= acc & ~rsp_r.pready & ~mapped;
            rsp_r.prdata <= {24'h000000, rd_byte};
        end
    end

    // software registers; hardware set of the flag wins over a clear
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            flag_r <= 1'b0;
            ack_en_r <= 1'b0;
            sta_r <= 1'b0;
            sto_r <= 1'b0;
            en_r <= 1'b0;
            go_r <= 1'b0;
            presc_r <= PRESC_RST;
            data_r <= DATA_RST;
            own_r <= OWN_RST;
            gce_r <= 1'b0;
        end else begin
            if (flag_set) begin
                flag_r <= 1'b1;
            end else if (clr_go) begin
                flag_r <= 1'b0;
            end
            if (ctl_wr) begin
                ack_en_r <= wd[ACK_BIT];
                sta_r <= wd[STA_REQ_BIT];
                en_r <= wd[EN_BIT];
            end
            if (ctl_wr) begin
                sto_r <= wd[STO_REQ_BIT];
            end else if (sto_clr) begin
                sto_r <= 1'b0; // R15
            end
            go_r <= clr_go;
            if (wr_ev & hit_stat) begin
                presc_r <= wd[PRESC_LSB +: 2];
            end
            if (wr_ev & hit_data) begin
                data_r <= wd;
            end
            if (wr_ev & hit_addr) begin
                own_r <= wd[OWN_LSB +: 7];
                gce_r <= wd[GCE_BIT];
            end
        end
    end

    // address match and frame decode
    wire own_hit = sh_r[7:1] == own_r;
    wire gc_hit = gce_r & (sh_r[7:1] == GEN_CALL_ADDR); // R10
    wire addr_hit = ack_en_r & sh_r[0] & (own_hit | gc_hit); // R21
    wire in_frame = (state_r == S_ADDR) | (state_r == S_AACK) |
                    (state_r == S_TX) | (state_r == S_TACK);
    wire frame_edge = (state_r == S_ADDR) & (cnt_r == 4'h0);
    wire bus_err = in_frame & ~frame_edge & (start_det | stop_det);
    wire may_load = (code_r == SC_OWN_RD) | (code_r == SC_ARB_RD) |
                    (code_r == SC_DATA_ACK);
    wire tdone = tmr_r == 10'h000;

    // engine next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ackd_nxt = ackd_r;
        last_nxt = last_r;
        rs_nxt = rs_r;
        code_nxt = code_r;
        flag_set = 1'b0;
        sto_clr = 1'b0;
        case (state_r)
            S_IDLE: begin
                if (start_det) begin
                    state_nxt = S_ADDR;
                    cnt_nxt = 4'h0;
                end else if (sta_r & ~busy_r & ~flag_r) begin
                    state_nxt = S_MSTART; // R11
                    rs_nxt = 1'b0;
                end
            end
            S_ADDR: begin
                if (start_det) begin
                    cnt_nxt = 4'h0;
                end else if (stop_det) begin
                    state_nxt = S_IDLE;
                end else if (scl_rise & (cnt_r != ADDR_BITS)) begin
                    sh_nxt = {sh_r[6:0], sda_now};
                    cnt_nxt = cnt_r + 4'h1;
                end else if (scl_fall & (cnt_r == ADDR_BITS)) begin
                    state_nxt = addr_hit ? S_AACK : S_IDLE; // R21
                end
            end
            S_AACK: begin
                if (scl_fall) begin
                    flag_set = 1'b1;
                    code_nxt = sta_r ? SC_ARB_RD : SC_OWN_RD; // R1 R2
                    state_nxt = S_HOLD;
                end
            end
            S_HOLD: begin
                if (go_r & may_load) begin
                    sh_nxt = data_r; // R6
                    last_nxt = ~ack_en_r; // R7 R8
                    cnt_nxt = 4'h0;
                    state_nxt = S_TX;
                end else if (go_r) begin
                    state_nxt = S_IDLE; // R9 R10 R11
                end
            end
            S_TX: begin
                if (scl_fall & (cnt_r == DATA_LAST)) begin
                    state_nxt = S_TACK;
                end else if (scl_fall) begin
                    sh_nxt = {sh_r[6:0], 1'b1};
                    cnt_nxt = cnt_r + 4'h1;
                end
            end
            S_TACK: begin
                if (scl_rise) begin
                    ackd_nxt = ~sda_now;
                end else if (scl_fall) begin
                    flag_set = 1'b1;
                    state_nxt = S_HOLD;
                    if (~ackd_r) begin
                        code_nxt = SC_DATA_NACK; // R4
                    end else if (last_r) begin
                        code_nxt = SC_LAST_ACK; // R5
                    end else begin
                        code_nxt = SC_DATA_ACK; // R3
                    end
                end
            end
            S_BERR: begin
                if (go_r) begin
                    state_nxt = S_IDLE; // R15
                    sto_clr = 1'b1; // R15
                end
            end
            S_MSTART: begin
                if (tdone) begin
                    flag_set = 1'b1;
                    code_nxt = rs_r ? SC_RSTART : SC_START;
                    state_nxt = S_MOWN;
                end
            end
            S_MOWN: begin
                if (go_r & sto_r) begin
                    state_nxt = S_MSTOP;
                end else if (go_r & sta_r) begin
                    state_nxt = S_MRS; // R17
                end
            end
            S_MRS: begin
                if (tdone) begin
                    state_nxt = S_MRSH;
                end
            end
            S_MRSH: begin
                if (tdone & scl_now) begin
                    state_nxt = S_MSTART; // R17
                    rs_nxt = 1'b1;
                end
            end
            S_MSTOP: begin
                if (tdone) begin
                    state_nxt = S_MSTOPH;
                end
            end
            S_MSTOPH: begin
                if (tdone) begin
                    state_nxt = S_IDLE;
                    sto_clr = 1'b1;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
        if (bus_err) begin
            state_nxt = S_BERR; // R13
            flag_set = 1'b1; // R13
            code_nxt = SC_BUS_ERR; // R13
        end
        if (~en_r) begin
            state_nxt = S_IDLE;
            flag_set = 1'b0;
        end
    end

    // engine registers and phase timer
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            state_r <= S_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'hFF;
            ackd_r <= 1'b0;
            last_r <= 1'b0;
            rs_r <= 1'b0;
            code_r <= SC_NONE;
            tmr_r <= PHASE_LD;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            ackd_r <= ackd_nxt;
            last_r <= last_nxt;
            rs_r <= rs_nxt;
            code_r <= code_nxt;
            if (state_nxt != state_r) begin
                tmr_r <= PHASE_LD;
            end else if (!tdone) begin
                tmr_r <= tmr_r - 10'h001;
            end
            if (start_det) begin
                busy_r <= 1'b1;
            end else if (stop_det) begin
                busy_r <= 1'b0;
            end
        end
    end

    // line drive decode; idle and error states leave both lines free
    wire tx_low = (state_r == S_TX) & ~sh_r[7]; // R22
    wire sda_drv = (state_r == S_AACK) | tx_low | (state_r == S_MSTART) |
                   (state_r == S_MOWN) | (state_r == S_MSTOP) |
                   (state_r == S_MSTOPH);
    wire scl_drv = (state_r == S_HOLD) | (state_r == S_MOWN) |
                   (state_r == S_MRS) | (state_r == S_MSTOP); // R19

    // pin output flops; driven level is always low
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            line_low_r <= 1'b0;
        end else begin
            scl_oe_r <= scl_drv & en_r;
            sda_oe_r <= sda_drv & en_r;
            line_low_r <= 1'b0;
        end
    end

    // outputs
    assign apb_rsp_out = rsp_r;
    assign scl_oe_out = scl_oe_r;
    assign sda_oe_out = sda_oe_r;
    assign scl_out = line_low_r;
    assign sda_out = line_low_r;
endmodule

// ### test/tws_slave_tx_checker.sv
// port-level assertions for the two-wire slave transmitter
`timescale 1ns/1ns
module tws_slave_tx_checker (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // apb slave
    input wire tws_pkg::tws_apb_req_type apb_req_in,
    input wire tws_pkg::tws_apb_rsp_type apb_rsp_out,
    // two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_out,
    input wire logic scl_oe_out,
    input wire logic sda_out,
    input wire logic sda_oe_out
);
    import tws_pkg::*;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);
    logic [10:0] since_wr_r;
    logic [10:0] since_wr_nxt;
    // decode of finished transfers
    wire done = apb_rsp_out.pready & apb_req_in.psel & apb_req_in.penable;
    wire stat_rd = done & ~apb_req_in.pwrite & (apb_req_in.paddr == STAT_OFS);
    wire ctrl_wr = done & apb_req_in.pwrite & (apb_req_in.paddr == CTRL_OFS);
    wire [4:0] code = apb_rsp_out.prdata[7:3];
    // saturating count of cycles since the last control write
    assign since_wr_nxt = ctrl_wr ? 11'h000 : since_wr_r + {10'h000, ~&since_wr_r};
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            since_wr_r <= 11'h000;
        end else begin
            since_wr_r <= since_wr_nxt;
        end
    end
    property p_rdy_wait;
        apb_req_in.psel && !apb_req_in.penable |=> !apb_rsp_out.pready ##1 apb_rsp_out.pready;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("pready not after one wait state");
    property p_rdy_pulse;
        apb_rsp_out.pready |=> !apb_rsp_out.pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
    property p_err_rdy;
        apb_rsp_out.pslverr |-> apb_rsp_out.pready;
    endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
    property p_stat_bits;
        stat_rd |-> apb_rsp_out.prdata[31:8] == 24'h000000 && !apb_rsp_out.prdata[2];
    endproperty
    a_stat_bits: assert property (p_stat_bits) else $error("status reserved bits set");
    property p_stretch;
        stat_rd && code != 5'h00 && code != 5'h1F |-> scl_oe_out;
    endproperty
    a_stretch: assert property (p_stretch) else $error("scl not held with flag set");
    property p_berr_free;
        stat_rd && code == 5'h00 |-> !scl_oe_out && !sda_oe_out;
    endproperty
    a_berr_free: assert property (p_berr_free) else $error("lines held after bus error");
    property p_open_drain;
        scl_out == 1'b0 && sda_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin drives a high level");
    property p_release;
        $fell(scl_oe_out) |-> since_wr_r < 11'h44C;
    endproperty
    a_release: assert property (p_release) else $error("scl released without flag write");
    c_own_rd: cover property (stat_rd && code == 5'h15);
    c_berr: cover property (stat_rd && code == 5'h00);
    c_slverr: cover property (apb_rsp_out.pslverr);
endmodule
bind tws_slave_tx tws_slave_tx_checker i_tws_slave_tx_checker (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out), .scl_in(scl_in),
    .sda_in(sda_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out));

// ### test/tws_mst_model.sv
// behavioural two-wire master receiver on the far side of the bus
`timescale 1ns/1ns
module tws_mst_model (
    // clock
    input wire logic core_clk_in,
    // resolved bus lines
    input wire logic scl_line_in,
    input wire logic sda_line_in,
    // pull-low enables of this master
    output logic scl_low_out,
    output logic sda_low_out
);
    int to_count = 0;
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end
    // half of the 160 ns bus clock period
    task automatic hp();
        repeat (8) @(posedge core_clk_in);
    endtask
    // release scl and wait while the slave stretches it
    task automatic rise();
        int n;
        n = 0;
        scl_low_out <= 1'b0;
        @(posedge core_clk_in);
        while (scl_line_in !== 1'b1 && n < 3000) begin
            @(posedge core_clk_in);
            n++;
        end
        if (n >= 3000) to_count++;
        hp();
    endtask
    // start: sda falls while scl is high
    task automatic start_c();
        sda_low_out <= 1'b1;
        hp();
        scl_low_out <= 1'b1;
        hp();
    endtask
    // repeated start keeps the bus between phases
    task automatic rstart_c();
        hp();
        sda_low_out <= 1'b0;
        hp();
        rise();
        sda_low_out <= 1'b1;
        hp();
        scl_low_out <= 1'b1;
        hp();
    endtask
    // stop: sda rises while scl is high, clock then stands still
    task automatic stop_c();
        hp();
        sda_low_out <= 1'b1;
        hp();
        rise();
        sda_low_out <= 1'b0;
        hp();
    endtask
    // one bit: data set while scl low, sampled while scl high
    task automatic xbit(input logic b, output logic r);
        hp();
        sda_low_out <= ~b;
        hp();
        rise();
        r = sda_line_in;
        scl_low_out <= 1'b1;
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] r,
        output logic a);
        logic t;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], t);
            r[i] = t;
        end
        xbit(ab, a);
    endtask
endmodule

// ### test/tb_top.sv
// self-checking bench for the two-wire slave transmitter
`timescale 1ns/1ns
module tb_top;
    import tws_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic er;} tws_row_type;
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    tws_apb_req_type req = '0;
    tws_apb_rsp_type rsp;
    logic scl_oe;
    logic sda_oe;
    logic m_scl;
    logic m_sda;
    logic [31:0] rd;
    logic err;
    logic [7:0] mr;
    logic ma;
    int n;
    int fail_count = 0;
    int comparisons = 0;
    tws_row_type rows [0:12] = '{'{1'h0, CTRL_OFS, 32'h00, 1'h0},
        '{1'h0, STAT_OFS, 32'hF8, 1'h0}, '{1'h0, DATA_OFS, 32'hFF, 1'h0},
        '{1'h0, ADDR_OFS, 32'h00, 1'h0}, '{1'h1, STAT_OFS, 32'h03, 1'h0},
        '{1'h0, STAT_OFS, 32'hFB, 1'h0}, '{1'h1, STAT_OFS, 32'h00, 1'h0},
        '{1'h0, 8'h10, 32'h00, 1'h1}, '{1'h1, 8'h10, 32'h5A, 1'h1},
        '{1'h1, ADDR_OFS, 32'hA5, 1'h0}, '{1'h0, ADDR_OFS, 32'hA5, 1'h0},
        '{1'h1, DATA_OFS, 32'hC3, 1'h0}, '{1'h0, DATA_OFS, 32'hC3, 1'h0}};
    // wired-and bus lines with pull-ups
    wire scl_w = ~(scl_oe | m_scl);
    wire sda_w = ~(sda_oe | m_sda);
    always #5 core_clk_in = ~core_clk_in;
    tws_slave_tx i_tws_slave_tx (.core_clk_in(core_clk_in), .srst_in(srst_in),
        .apb_req_in(req), .apb_rsp_out(rsp), .scl_in(scl_w), .sda_in(sda_w), .scl_out(),
        .scl_oe_out(scl_oe), .sda_out(), .sda_oe_out(sda_oe));
    tws_mst_model i_tws_mst_model (.core_clk_in(core_clk_in), .scl_line_in(scl_w),
        .sda_line_in(sda_w), .scl_low_out(m_scl), .sda_low_out(m_sda));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, request held until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge core_clk_in);
        req.penable <= 1'b1;
        do begin
            @(posedge core_clk_in);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        chk(32'(k >= 20), 32'h0);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge core_clk_in);
    endtask
    // poll the status code until it shows the expected value
    task automatic st(input logic [7:0] exp);
        int k;
        k = 0;
        do begin
            apb(1'b0, STAT_OFS, 32'h0);
            k++;
        end while (rd !== {24'h0, exp} && k < 600);
        chk(rd, {24'h0, exp});
    endtask
    task automatic mb(input logic [7:0] d, input logic ab);
        i_tws_mst_model.xbyte(d, ab, mr, ma);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge core_clk_in);
        fail_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        results();
    end
    initial begin
        repeat (20) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(posedge core_clk_in);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].d);
            chk(err, rows[i].er);
        end
        $display("test register rows done");
        // write direction is not taken, read direction is
        apb(1'b1, CTRL_OFS, 32'h44);
        i_tws_mst_model.start_c();
        mb(8'hA4, 1'b1);
        chk(ma, 1'b1);
        i_tws_mst_model.stop_c();
        i_tws_mst_model.start_c();
        mb(8'hA5, 1'b1);
        chk(ma, 1'b0);
        st(SC_OWN_RD);
        chk(scl_oe, 1'b1);
        apb(1'b1, CTRL_OFS, 32'hC4);
        mb(8'hFF, 1'b0);
        chk(mr, 8'hC3);
        st(SC_DATA_ACK);
        apb(1'b1, DATA_OFS, 32'h3C);
        apb(1'b1, CTRL_OFS, 32'h84);
        mb(8'hFF, 1'b0);
        chk(mr, 8'h3C);
        st(SC_LAST_ACK);
        apb(1'b1, CTRL_OFS, 32'h84);
        mb(8'hFF, 1'b1);
        chk(mr, 8'hFF);
        i_tws_mst_model.rstart_c();
        mb(8'hA5, 1'b1);
        chk(ma, 1'b1);
        i_tws_mst_model.stop_c();
        $display("test slave transmit done");
        // general call ignored without its enable, then nack ends the transfer
        apb(1'b1, ADDR_OFS, 32'hA4);
        apb(1'b1, CTRL_OFS, 32'h44);
        i_tws_mst_model.start_c();
        mb(8'h01, 1'b1);
        chk(ma, 1'b1);
        i_tws_mst_model.stop_c();
        i_tws_mst_model.start_c();
        mb(8'hA5, 1'b1);
        st(SC_OWN_RD);
        apb(1'b1, DATA_OFS, 32'h96);
        apb(1'b1, CTRL_OFS, 32'hC4);
        mb(8'hFF, 1'b1);
        chk(mr, 8'h96);
        st(SC_DATA_NACK);
        apb(1'b1, CTRL_OFS, 32'hE4);
        i_tws_mst_model.rstart_c();
        mb(8'hA5, 1'b1);
        chk(ma, 1'b0);
        st(SC_ARB_RD);
        apb(1'b1, DATA_OFS, 32'hFF);
        apb(1'b1, CTRL_OFS, 32'hC4);
        $display("test nack and lost bus done");
        // stop in mid-byte is a bus error
        for (int i = 0; i < 3; i++) begin
            i_tws_mst_model.xbit(1'b1, ma);
        end
        i_tws_mst_model.stop_c();
        st(SC_BUS_ERR);
        chk({scl_oe, sda_oe}, 2'b00);
        apb(1'b1, CTRL_OFS, 32'hD4);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h44);
        st(SC_NONE);
        $display("test bus error done");
        // master start, repeated start, then stop
        apb(1'b1, CTRL_OFS, 32'h64);
        st(SC_START);
        chk({scl_w, sda_w}, 2'b00);
        apb(1'b1, CTRL_OFS, 32'hA4);
        st(SC_RSTART);
        chk(scl_oe, 1'b1);
        apb(1'b1, CTRL_OFS, 32'h94);
        n = 0;
        while ((scl_w & sda_w) !== 1'b1 && n < 3000) begin
            @(posedge core_clk_in);
            n++;
        end
        chk({scl_w, sda_w}, 2'b11);
        st(SC_NONE);
        chk(i_tws_mst_model.to_count, 32'h0);
        $display("test master conditions done");
        // mid-run reset returns registers and pins to their reset state
        apb(1'b1, STAT_OFS, 32'h03);
        srst_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(posedge core_clk_in);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd, 32'hF8);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        chk({scl_oe, sda_oe}, 2'b00);
        $display("test reset done");
        results();
    end
endmodule
